// ---- rtl/pmd_cmd_decoder.v ----
// Power-manager command decoder: takes address, command and data bytes from
// the serial engine, executes on stop, holds rail settings.
// Assumes byte, start and stop strobes come from logic on clk_in.
`timescale 1ns/1ps

`include "pmd_defines.vh"

module pmd_cmd_decoder (
	// Clock and reset
	input  wire        clk_in,
	input  wire        rst_n_in,
	// Pins
	input  wire        addr_strap_in,
	input  wire        supply_good_flag_in,
	// Byte stream from serial engine
	input  wire        start_in,
	input  wire        stop_in,
	input  wire        byte_valid_in,
	input  wire [7:0]  byte_in,
	output wire        byte_ack_out,
	// Rail references
	input  wire [11:0] core_voltage_id_reference_in,
	input  wire [11:0] uncore_voltage_id_reference_in,
	// Light-load inputs
	input  wire        cpu_power_save_request_n_in,
	input  wire        light_load_in,
	// Rail targets
	output wire [12:0] core_target_mv_out,
	output wire [12:0] uncore_target_mv_out,
	output wire [13:0] core_ovp_trip_mv_out,
	output wire [13:0] uncore_ovp_trip_mv_out,
	// Settings
	output reg  [1:0]  core_ovp_code_out,
	output reg  [1:0]  uncore_ovp_code_out,
	output reg  [2:0]  freq_trim_code_out,
	output reg  [1:0]  core_droop_factor_out,
	output reg  [1:0]  uncore_droop_factor_out,
	output reg  [1:0]  phase_shed_threshold_out,
	output reg         light_load_action_out,
	output reg         light_load_enable_out,
	output reg         auto_phase_enable_out,
	// Phase shedding and status
	output reg         shed_active_out,
	output reg  [1:0]  shed_phase_count_out,
	output reg         cmd_done_out
);

	localparam S_IDLE = 3'h0;
	localparam S_ADDR = 3'h1;
	localparam S_CMD  = 3'h2;
	localparam S_DATA = 3'h3;
	localparam S_FULL = 3'h4;
	localparam S_SKIP = 3'h5;

	// Reset release and pin synchronisers
	reg         rst_meta_ff;
	reg         rst_sync_ff;
	reg  [1:0]  strap_sync_ff;
	reg  [1:0]  good_sync_ff;
	wire        rst_n;
	wire        strap;
	wire        good;

	// Frame state
	reg  [2:0]  st_ff;
	reg  [2:0]  nxt_st;
	reg  [7:0]  cmd_ff;
	reg  [7:0]  data_ff;
	wire        addr_hit;
	wire        exec;

	// Settings
	reg  [4:0]  core_off_code_ff;
	reg         core_off_neg_ff;
	reg  [4:0]  unc_off_code_ff;
	wire [2:0]  code;
	wire        sel_core;
	wire        sel_unc;
	wire        sign_pos;
	wire [4:0]  mag;
	wire [4:0]  unc_mag;
	wire [10:0] core_off_mv;
	wire [10:0] unc_off_mv;
	wire [9:0]  core_ovp_mv;
	wire [9:0]  unc_ovp_mv_raw;
	wire [9:0]  unc_ovp_mv;
	wire        save_req;
	wire        shed;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	assign rst_n = rst_sync_ff;

	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			strap_sync_ff <= 2'h0;
			good_sync_ff  <= 2'h0;
		end else begin
			strap_sync_ff <= {strap_sync_ff[0], addr_strap_in};
			good_sync_ff  <= {good_sync_ff[0], supply_good_flag_in};
		end
	end

	assign strap = strap_sync_ff[1];
	assign good  = good_sync_ff[1];

	// Address match and acknowledge
	assign addr_hit = (byte_in == {`PMD_ADDR_PREFIX, strap, `PMD_WRITE_BIT});
	assign byte_ack_out = byte_valid_in && !start_in && !stop_in && good &&
		(((st_ff == S_ADDR) && addr_hit) || (st_ff == S_CMD) || (st_ff == S_DATA));
	assign exec = stop_in && !start_in && (st_ff == S_FULL) && good;

	always @* begin
		nxt_st = st_ff;
		if (start_in) begin
			nxt_st = good ? S_ADDR : S_SKIP;
		end else if (stop_in) begin
			nxt_st = S_IDLE;
		end else if (!good) begin
			nxt_st = (st_ff == S_IDLE) ? S_IDLE : S_SKIP;
		end else if (byte_valid_in) begin
			case (st_ff)
				S_ADDR:  nxt_st = addr_hit ? S_CMD : S_SKIP;
				S_CMD:   nxt_st = S_DATA;
				S_DATA:  nxt_st = S_FULL;
				S_FULL:  nxt_st = S_SKIP;
				S_SKIP:  nxt_st = S_SKIP;
				default: nxt_st = S_IDLE;
			endcase
		end
	end

	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			st_ff        <= S_IDLE;
			cmd_ff       <= 8'h00;
			data_ff      <= 8'h00;
			cmd_done_out <= 1'b0;
		end else begin
			st_ff        <= nxt_st;
			cmd_done_out <= exec;
			if (byte_ack_out && (st_ff == S_CMD)) begin
				cmd_ff <= byte_in;
			end
			if (byte_ack_out && (st_ff == S_DATA)) begin
				data_ff <= byte_in;
			end
		end
	end

	// Field extraction
	assign code     = cmd_ff[`PMD_CMD_MSB:`PMD_CMD_LSB];
	assign sel_core = cmd_ff[`PMD_SEL_CORE_BIT];
	assign sel_unc  = cmd_ff[`PMD_SEL_UNCORE_BIT];
	assign sign_pos = data_ff[`PMD_SIGN_BIT];
	assign mag      = data_ff[`PMD_MAG_MSB:`PMD_MAG_LSB];
	assign unc_mag  = ({6'h00, mag} * `PMD_OFF_STEP_MV > `PMD_UNCORE_MAX_OFF_MV) ?
		`PMD_UNC_MAX_CODE : mag;

	// Command execution at stop
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			core_off_code_ff         <= 5'h00;
			core_off_neg_ff          <= 1'b0;
			unc_off_code_ff          <= 5'h00;
			core_ovp_code_out        <= `PMD_OVP_RST;
			uncore_ovp_code_out      <= `PMD_OVP_RST;
			freq_trim_code_out       <= `PMD_FREQ_RST;
			core_droop_factor_out    <= `PMD_DROOP_QUARTER;
			uncore_droop_factor_out  <= `PMD_DROOP_QUARTER;
			phase_shed_threshold_out <= `PMD_SHED_TH_RST;
			light_load_action_out    <= `PMD_ACTION_RST;
			light_load_enable_out    <= `PMD_LL_EN_RST;
			auto_phase_enable_out    <= `PMD_AUTO_RST;
		end else if (exec) begin
			if (cmd_ff[`PMD_BOOST_BIT]) begin
				if (sel_core) begin
					core_off_code_ff <= mag;
					core_off_neg_ff  <= !sign_pos;
				end
				if (sel_unc && sign_pos) begin
					unc_off_code_ff <= unc_mag;
				end
			end else begin
				case (code)
					`PMD_CMD_OVP: begin
						uncore_ovp_code_out <= data_ff[`PMD_UNC_FLD_MSB:`PMD_UNC_FLD_LSB];
						core_ovp_code_out   <= data_ff[`PMD_CORE_FLD_MSB:`PMD_CORE_FLD_LSB];
					end
					`PMD_CMD_FREQ: begin
						if ((data_ff[`PMD_FREQ_MSB:`PMD_FREQ_LSB] != `PMD_FREQ_IGN_A) &&
							(data_ff[`PMD_FREQ_MSB:`PMD_FREQ_LSB] != `PMD_FREQ_IGN_B)) begin
							freq_trim_code_out <= data_ff[`PMD_FREQ_MSB:`PMD_FREQ_LSB];
						end
					end
					`PMD_CMD_DROOP: begin
						if (data_ff[`PMD_UNC_FLD_MSB:`PMD_UNC_FLD_LSB] != `PMD_DROOP_IGNORED) begin
							uncore_droop_factor_out <= data_ff[`PMD_UNC_FLD_MSB:`PMD_UNC_FLD_LSB];
						end
						if (data_ff[`PMD_CORE_FLD_MSB:`PMD_CORE_FLD_LSB] != `PMD_DROOP_IGNORED) begin
							core_droop_factor_out <= data_ff[`PMD_CORE_FLD_MSB:`PMD_CORE_FLD_LSB];
						end
					end
					`PMD_CMD_FLAGS: begin
						phase_shed_threshold_out <= data_ff[`PMD_SHED_TH_MSB:`PMD_SHED_TH_LSB];
						light_load_action_out    <= data_ff[`PMD_ACTION_BIT];
						light_load_enable_out    <= data_ff[`PMD_LL_EN_BIT];
						auto_phase_enable_out    <= data_ff[`PMD_AUTO_BIT];
					end
					default: begin
						core_off_neg_ff <= core_off_neg_ff;
					end
				endcase
			end
		end
	end

	// Offset and threshold in millivolts
	assign core_off_mv = {6'h00, core_off_code_ff} * `PMD_OFF_STEP_MV;
	assign unc_off_mv  = {6'h00, unc_off_code_ff} * `PMD_OFF_STEP_MV;
	assign core_ovp_mv = `PMD_OVP_BASE_MV + ({8'h00, core_ovp_code_out} * `PMD_OVP_STEP_MV);
	assign unc_ovp_mv_raw = `PMD_OVP_BASE_MV +
		({8'h00, uncore_ovp_code_out} * `PMD_OVP_STEP_MV);
	assign unc_ovp_mv  = (unc_ovp_mv_raw > `PMD_OVP_UNC_CAP_MV) ?
		`PMD_OVP_UNC_CAP_MV : unc_ovp_mv_raw;

	pmd_rail_target u_core (
		.clk_in          (clk_in),
		.rst_n_in        (rst_n),
		.ref_mv_in       (core_voltage_id_reference_in),
		.off_mv_in       (core_off_mv),
		.off_neg_in      (core_off_neg_ff),
		.max_mv_in       (`PMD_CORE_MAX_MV),
		.ovp_mv_in       (core_ovp_mv),
		.target_mv_out   (core_target_mv_out),
		.ovp_trip_mv_out (core_ovp_trip_mv_out)
	);

	pmd_rail_target u_uncore (
		.clk_in          (clk_in),
		.rst_n_in        (rst_n),
		.ref_mv_in       (uncore_voltage_id_reference_in),
		.off_mv_in       (unc_off_mv),
		.off_neg_in      (1'b0),
		.max_mv_in       (`PMD_NO_CLAMP_MV),
		.ovp_mv_in       (unc_ovp_mv),
		.target_mv_out   (uncore_target_mv_out),
		.ovp_trip_mv_out (uncore_ovp_trip_mv_out)
	);

	// Light-load phase shedding on the core rail
	assign save_req = light_load_enable_out && !cpu_power_save_request_n_in;
	assign shed     = save_req || (auto_phase_enable_out && light_load_in);

	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			shed_active_out      <= 1'b0;
			shed_phase_count_out <= 2'h1;
		end else begin
			shed_active_out      <= shed;
			shed_phase_count_out <= light_load_action_out ? 2'h2 : 2'h1;
		end
	end

endmodule // pmd_cmd_decoder

// ---- rtl/pmd_defines.vh ----
// Constants for the power-manager command decoder: address, command codes,
// field positions, reset values and voltage figures in millivolts.
`ifndef PMD_DEFINES_VH
`define PMD_DEFINES_VH

// Address byte: six fixed bits, strap bit, write bit
`define PMD_ADDR_PREFIX      6'h33
`define PMD_WRITE_BIT        1'h0

// Command code field (byte bits 4:2)
`define PMD_CMD_MSB          4
`define PMD_CMD_LSB          2
`define PMD_CMD_OVP          3'h0
`define PMD_CMD_FREQ         3'h1
`define PMD_CMD_DROOP        3'h2
`define PMD_CMD_FLAGS        3'h3
`define PMD_BOOST_BIT        4
`define PMD_SEL_CORE_BIT     3
`define PMD_SEL_UNCORE_BIT   2

// Offset-boost data fields
`define PMD_SIGN_BIT         5
`define PMD_MAG_MSB          4
`define PMD_MAG_LSB          0
`define PMD_OFF_STEP_MV      11'h032
`define PMD_CORE_MAX_MV      13'haf0
`define PMD_UNCORE_MAX_OFF_MV 11'h258
`define PMD_UNC_MAX_CODE     5'h0c
`define PMD_NO_CLAMP_MV      13'h1fff

// Two-bit fields shared by threshold and droop commands
`define PMD_UNC_FLD_MSB      3
`define PMD_UNC_FLD_LSB      2
`define PMD_CORE_FLD_MSB     1
`define PMD_CORE_FLD_LSB     0

// Overvoltage threshold: base, step, uncore cap
`define PMD_OVP_BASE_MV      10'h0fa
`define PMD_OVP_STEP_MV      10'h0c8
`define PMD_OVP_UNC_CAP_MV   10'h28a
`define PMD_OVP_RST          2'h0

// Frequency trim field and ignored codes
`define PMD_FREQ_MSB         2
`define PMD_FREQ_LSB         0
`define PMD_FREQ_IGN_A       3'h3
`define PMD_FREQ_IGN_B       3'h7
`define PMD_FREQ_RST         3'h0

// Droop factor codes
`define PMD_DROOP_QUARTER    2'h0
`define PMD_DROOP_IGNORED    2'h2

// Flags command fields and reset values
`define PMD_SHED_TH_MSB      4
`define PMD_SHED_TH_LSB      3
`define PMD_ACTION_BIT       2
`define PMD_LL_EN_BIT        1
`define PMD_AUTO_BIT         0
`define PMD_SHED_TH_RST      2'h0
`define PMD_ACTION_RST       1'h0
`define PMD_LL_EN_RST        1'h1
`define PMD_AUTO_RST         1'h0

`endif

// ---- rtl/pmd_rail_target.v ----
// Per-rail target: reference plus signed offset, with an upper clamp unless off_neg_in is set, and
// the overvoltage trip level above that target. Same clock as its user.
`timescale 1ns/1ps

`include "pmd_defines.vh"

module pmd_rail_target (
	// Clock and reset
	input  wire        clk_in,
	input  wire        rst_n_in,
	// Settings
	input  wire [11:0] ref_mv_in,
	input  wire [10:0] off_mv_in,
	input  wire        off_neg_in,
	input  wire [12:0] max_mv_in,
	input  wire [9:0]  ovp_mv_in,
	// Results
	output reg  [12:0] target_mv_out,
	output reg  [13:0] ovp_trip_mv_out
);

	wire [12:0] sum_mv;
	wire [12:0] dif_mv;
	reg  [12:0] nxt_target;

	assign sum_mv = {1'b0, ref_mv_in} + {2'h0, off_mv_in};
	assign dif_mv = ({1'b0, ref_mv_in} > {2'h0, off_mv_in}) ?
		({1'b0, ref_mv_in} - {2'h0, off_mv_in}) : 13'h0000;

	always @* begin
		if (off_neg_in) begin
			nxt_target = dif_mv;
		end else if (sum_mv > max_mv_in) begin
			nxt_target = max_mv_in;
		end else begin
			nxt_target = sum_mv;
		end
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			target_mv_out   <= 13'h0000;
			ovp_trip_mv_out <= 14'h0000;
		end else begin
			target_mv_out   <= nxt_target;
			ovp_trip_mv_out <= {1'b0, nxt_target} + {4'h0, ovp_mv_in};
		end
	end

endmodule // pmd_rail_target

// ---- dv/pmd_cmd_decoder_props.sv ----
// Port checker for the command decoder, bound to the top module.
// Assumes one clock, clk_in, and the asynchronous reset rst_n_in.
`timescale 1ns/1ps
module pmd_cmd_decoder_props (
	// Clock and reset
	input wire        clk_in,
	input wire        rst_n_in,
	// Byte stream and pins
	input wire        supply_good_flag_in,
	input wire        stop_in,
	input wire        byte_valid_in,
	input wire        byte_ack_out,
	input wire        cmd_done_out,
	input wire        cpu_power_save_request_n_in,
	input wire        light_load_in,
	input wire [11:0] uncore_voltage_id_reference_in,
	// Settings and targets
	input wire [12:0] core_target_mv_out,
	input wire [12:0] uncore_target_mv_out,
	input wire [1:0]  core_ovp_code_out,
	input wire        light_load_action_out,
	input wire        light_load_enable_out,
	input wire        auto_phase_enable_out,
	input wire        shed_active_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_ack_valid;
		byte_ack_out |-> byte_valid_in;
	endproperty
	a_ack_valid: assert property (p_ack_valid) else $error("ack without byte");
	property p_done_stop;
		cmd_done_out |-> $past(stop_in);
	endproperty
	a_done_stop: assert property (p_done_stop) else $error("done without stop");
	property p_done_pulse;
		cmd_done_out |=> !cmd_done_out;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done too long");
	property p_good;
		byte_ack_out |-> $past(supply_good_flag_in, 2);
	endproperty
	a_good: assert property (p_good) else $error("ack while supply low");
	property p_clamp;
		core_target_mv_out <= 13'haf0;
	endproperty
	a_clamp: assert property (p_clamp) else $error("core target above clamp");
	property p_unc_lim;
		uncore_target_mv_out <= {1'h0, $past(uncore_voltage_id_reference_in)} + 13'h258;
	endproperty
	a_unc_lim: assert property (p_unc_lim) else $error("uncore offset too big");
	property p_chg;
		$changed({core_ovp_code_out, light_load_action_out}) |-> cmd_done_out;
	endproperty
	a_chg: assert property (p_chg) else $error("setting changed alone");
	property p_shed;
		shed_active_out == $past((light_load_enable_out && !cpu_power_save_request_n_in)
			|| (auto_phase_enable_out && light_load_in));
	endproperty
	a_shed: assert property (p_shed) else $error("shed state wrong");
endmodule // pmd_cmd_decoder_props

bind pmd_cmd_decoder pmd_cmd_decoder_props u_props (.clk_in, .rst_n_in, .supply_good_flag_in,
	.stop_in, .byte_valid_in, .byte_ack_out, .cmd_done_out, .cpu_power_save_request_n_in,
	.light_load_in, .uncore_voltage_id_reference_in, .core_target_mv_out,
	.uncore_target_mv_out, .core_ovp_code_out, .light_load_action_out,
	.light_load_enable_out, .auto_phase_enable_out, .shed_active_out);

// ---- dv/pmd_i2c_master_model.sv ----
// Bus master model: start, address, command and data strobes, then stop.
// Assumes the decoder's clk_in; drives 1 ns after rising edges.
`timescale 1ns/1ps
module pmd_i2c_master_model (
	// Clock and answer
	input  wire       clk_in,
	input  wire       ack_in,
	// Byte stream
	output reg        start_out,
	output reg        stop_out,
	output reg        valid_out,
	output reg  [7:0] byte_out
);
	reg [2:0] acks;
	reg       ack_ff;
	initial begin
		start_out = 1'h0;
		stop_out = 1'h0;
		valid_out = 1'h0;
		byte_out = 8'h00;
		acks = 3'h0;
		ack_ff = 1'h0;
	end
	always @(posedge clk_in) begin
		ack_ff <= ack_in & valid_out;
	end
	// Bytes back to back; a released line shows the inverse value
	task frame(input [7:0] a, input [7:0] c, input [7:0] d, input integer n);
		integer   i;
		reg [23:0] q;
		begin
			q = {a, c, d};
			@(posedge clk_in) #1 start_out = 1'h1;
			for (i = 0; i < n; i = i + 1) begin
				@(posedge clk_in) #1 start_out = 1'h0;
				if (i > 0)
					acks = {acks[1:0], ack_ff};
				valid_out = 1'h1;
				byte_out = q[23:16];
				q = q << 8;
			end
			@(posedge clk_in) #1 valid_out = 1'h0;
			acks = {acks[1:0], ack_ff};
			byte_out = ~byte_out;
			stop_out = 1'h1;
			@(posedge clk_in) #1 stop_out = 1'h0;
		end
	endtask
endmodule // pmd_i2c_master_model

// ---- dv/tb_pmd_cmd_decoder.sv ----
// Self-checking bench: command frames through the master model.
// Assumes a 25 MHz clock and 1000 mV rail references, the core one raised to 1500 mV for the last frames.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
	n_mismatch = n_mismatch + 1; $display("ERROR %s exp %0d got %0d", nm, e, g); end end
module tb_pmd_cmd_decoder;
	localparam [11:0] REF = 12'h3e8;
	localparam [7:0]  ADR = 8'hcc;
	reg         clk_in, rst_n_in, addr_strap_in, supply_good_flag_in;
	reg         cpu_power_save_request_n_in, light_load_in;
	reg  [11:0] core_voltage_id_reference_in, uncore_voltage_id_reference_in;
	wire        start_in, stop_in, byte_valid_in, byte_ack_out, cmd_done_out;
	wire [7:0]  byte_in;
	wire [12:0] core_target_mv_out, uncore_target_mv_out;
	wire [13:0] core_ovp_trip_mv_out, uncore_ovp_trip_mv_out;
	wire [1:0]  core_ovp_code_out, uncore_ovp_code_out, core_droop_factor_out;
	wire [1:0]  uncore_droop_factor_out, phase_shed_threshold_out, shed_phase_count_out;
	wire [2:0]  freq_trim_code_out;
	wire        light_load_action_out, light_load_enable_out, auto_phase_enable_out;
	wire        shed_active_out;
	integer     n_mismatch, n_tests, k;
	pmd_cmd_decoder dut (.clk_in, .rst_n_in, .addr_strap_in, .supply_good_flag_in, .start_in,
		.stop_in, .byte_valid_in, .byte_in, .byte_ack_out, .core_voltage_id_reference_in,
		.uncore_voltage_id_reference_in, .cpu_power_save_request_n_in, .light_load_in,
		.core_target_mv_out, .uncore_target_mv_out, .core_ovp_trip_mv_out,
		.uncore_ovp_trip_mv_out, .core_ovp_code_out, .uncore_ovp_code_out,
		.freq_trim_code_out, .core_droop_factor_out, .uncore_droop_factor_out,
		.phase_shed_threshold_out, .light_load_action_out, .light_load_enable_out,
		.auto_phase_enable_out, .shed_active_out, .shed_phase_count_out, .cmd_done_out);
	pmd_i2c_master_model mst (.clk_in, .ack_in(byte_ack_out), .start_out(start_in),
		.stop_out(stop_in), .valid_out(byte_valid_in), .byte_out(byte_in));
	always #20 clk_in = ~clk_in;
	task send(input [7:0] a, input [7:0] c, input [7:0] d, input [2:0] ea, input ed);
		begin
			mst.frame(a, c, d, 3);
			`CHK("done", ed, cmd_done_out)
			`CHK("acks", ea, mst.acks)
			repeat (2) @(posedge clk_in);
			#1;
		end
	endtask
	task complete_run;
		begin
			if (n_mismatch == 0 && n_tests > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		#100000;
		n_mismatch = n_mismatch + 1;
		complete_run;
	end
	initial begin
		{clk_in, rst_n_in, addr_strap_in, supply_good_flag_in, light_load_in} = 5'h0;
		cpu_power_save_request_n_in = 1'h1;
		core_voltage_id_reference_in = REF;
		uncore_voltage_id_reference_in = REF;
		n_mismatch = 0;
		n_tests = 0;
		repeat (2) @(posedge clk_in);
		#1 rst_n_in = 1'h1;
		repeat (6) @(posedge clk_in);
		#1;
		`CHK("core_trip", REF + 250, core_ovp_trip_mv_out)
		`CHK("unc_trip", REF + 250, uncore_ovp_trip_mv_out)
		`CHK("droop", 4'h0, {core_droop_factor_out, uncore_droop_factor_out})
		`CHK("shed_th", 2'h0, phase_shed_threshold_out)
		`CHK("flags", 3'h2, {light_load_action_out, light_load_enable_out,
			auto_phase_enable_out})
		send(ADR, 8'h00, 8'h0f, 3'h0, 1'h0);
		`CHK("core_ovp", 2'h0, core_ovp_code_out)
		supply_good_flag_in = 1'h1;
		repeat (3) @(posedge clk_in);
		#1;
		send(ADR, 8'he3, 8'hf9, 3'h7, 1'h1);
		`CHK("ovp_codes", 4'h6, {core_ovp_code_out, uncore_ovp_code_out})
		`CHK("unc_trip", REF + 650, uncore_ovp_trip_mv_out)
		send(ADR, 8'h18, 8'he5, 3'h7, 1'h1);
		`CHK("core_t", REF + 250, core_target_mv_out)
		`CHK("unc_t", REF, uncore_target_mv_out)
		`CHK("core_trip", REF + 700, core_ovp_trip_mv_out)
		send(ADR, 8'h1c, 8'h04, 3'h7, 1'h1);
		`CHK("core_t", REF - 200, core_target_mv_out)
		`CHK("unc_t", REF, uncore_target_mv_out)
		send(ADR, 8'h14, 8'h2b, 3'h7, 1'h1);
		`CHK("unc_t", REF + 550, uncore_target_mv_out)
		core_voltage_id_reference_in = 12'h5dc;
		send(ADR, 8'h1c, 8'h3f, 3'h7, 1'h1);
		`CHK("core_t", 2800, core_target_mv_out)
		`CHK("unc_t", REF + 600, uncore_target_mv_out)
		send(ADR, 8'h10, 8'h21, 3'h7, 1'h1);
		`CHK("core_t", 2800, core_target_mv_out)
		for (k = 0; k < 2; k = k + 1) begin
			send(ADR ^ (8'h2 >> k), 8'h04, 8'h05, 3'h0, 1'h0);
			`CHK("freq", 3'h0, freq_trim_code_out)
		end
		send(ADR, 8'h04, 8'hfd, 3'h7, 1'h1);
		send(ADR, 8'h04, 8'h03, 3'h7, 1'h1);
		`CHK("freq", 3'h5, freq_trim_code_out)
		mst.frame(ADR, 8'h04, 8'h02, 2);
		`CHK("done", 1'h0, cmd_done_out)
		send(ADR, 8'h08, 8'h07, 3'h7, 1'h1);
		`CHK("droop", 4'hd, {core_droop_factor_out, uncore_droop_factor_out})
		`CHK("freq", 3'h5, freq_trim_code_out)
		send(ADR, 8'h0c, 8'hff, 3'h7, 1'h1);
		`CHK("shed_th", 2'h3, phase_shed_threshold_out)
		`CHK("flags", 3'h7, {light_load_action_out, light_load_enable_out,
			auto_phase_enable_out})
		light_load_in = 1'h1;
		repeat (2) @(posedge clk_in);
		#1;
		`CHK("shed", 3'h6, {shed_active_out, shed_phase_count_out})
		send(ADR, 8'h0c, 8'h08, 3'h7, 1'h1);
		cpu_power_save_request_n_in = 1'h0;
		repeat (2) @(posedge clk_in);
		#1;
		`CHK("shed", 1'h0, shed_active_out)
		`CHK("droop", 2'h3, core_droop_factor_out)
		send(ADR, 8'h0c, 8'h02, 3'h7, 1'h1);
		`CHK("shed", 3'h5, {shed_active_out, shed_phase_count_out})
		complete_run;
	end
endmodule // tb_pmd_cmd_decoder
